// [hw/aimx_top.v]
// Input mux select, scan mask and pin configuration registers with latching
`timescale 1ns/1ps
// How it works
// - depth code n gives 2**n buffer words per input, 1 to 128.
// - sample B channel 1-3 negative: 11 inputs 9-11, 10 inputs 6-8, else ref.
// - sample B channel 1-3 positive bit: 1 inputs 3-5, 0 inputs 0-2.
// - sample A channel 1-3 negative uses the same encoding as sample B.
// - sample A channel 1-3 positive bit: 1 inputs 3-5, 0 inputs 0-2.
// - in 12-bit mode channel 1-3 selects ignore writes, read zero.
// - channel 0 negative bit: 1 selects input 1, 0 the negative reference.
// - channel 0 positive field value equals the input number, 0 to 31.
// - second instance limits channel 0 positive select to inputs 0-15.
// - scan mask bit x includes input x in the scan when set.
// - all mask bits writable; nonexistent scanned input converts reference.
// - pin config 1 gives digital pin and grounded channel 0 positive mux; 0 analog.
// - pin config bits always read/write; bits without pins do nothing.
// - module disabled makes all shared pins digital, config ignored.
// - only the first instance has the high pin configuration register.
// - unimplemented bits ignore writes, read zero; all reset to zero but the status scan pointer, 31.
// - 12-bit mode is one channel; otherwise four channels with 1-3 selects.
// - alternate mode uses sample A then sample B; otherwise always A.
// - scan mode steps channel 0 positive in sample A through the mask.
`include "aimx_defines.vh"

module aimx_top #(
	parameter       ADDR_W       = 8,
	parameter       NUM_INPUTS   = 32,
	parameter       INSTANCE_TWO = 0
) (
	input  wire              CORE_CLK_I,
	input  wire              RESET_N_I,
	input  wire [ADDR_W-1:0] S_AXI_AWADDR_I,
	input  wire              S_AXI_AWVALID_I,
	output wire              S_AXI_AWREADY_O,
	input  wire [31:0]       S_AXI_WDATA_I,
	input  wire [3:0]        S_AXI_WSTRB_I,
	input  wire              S_AXI_WVALID_I,
	output wire              S_AXI_WREADY_O,
	output reg  [1:0]        S_AXI_BRESP_O,
	output reg               S_AXI_BVALID_O,
	input  wire              S_AXI_BREADY_I,
	input  wire [ADDR_W-1:0] S_AXI_ARADDR_I,
	input  wire              S_AXI_ARVALID_I,
	output wire              S_AXI_ARREADY_O,
	output reg  [31:0]       S_AXI_RDATA_O,
	output reg  [1:0]        S_AXI_RRESP_O,
	output reg               S_AXI_RVALID_O,
	input  wire              S_AXI_RREADY_I,
	input  wire              WIDE_RESOLUTION_MODE_I,
	input  wire              ALTERNATE_SAMPLE_ENABLE_I,
	input  wire              SCAN_ENABLE_I,
	input  wire              CONVERTER_MODULE_DISABLE_I,
	input  wire [15:0]       PIN_DIGITAL_LOW_I,
	input  wire              SAMPLE_START_I,
	input  wire              CONVERSION_DONE_I,
	output reg  [7:0]        BUFFER_WORDS_O,
	output reg               ACTIVE_SAMPLE_B_O,
	output reg               SAMPLE_HOLD_O,
	output reg  [4:0]        CH0_POS_O,
	output reg               CH0_POS_REF_O,
	output reg               CH0_POS_AGND_O,
	output reg               CH0_NEG_AN1_O,
	output reg  [14:0]       CH123_POS_O,
	output reg  [14:0]       CH123_NEG_O,
	output reg  [2:0]        CH123_NEG_REF_O,
	output reg  [15:0]       PIN_DIGITAL_HIGH_O
);

	// ======================================================================
	// Register storage
	reg  [15:0] depth_ff;
	reg  [15:0] chs123_ff;
	reg  [15:0] chs0_ff;
	reg  [15:0] scan_hi_ff;
	reg  [15:0] scan_lo_ff;
	reg  [15:0] pin_digital_select_hi_ff;
	reg         busy_ff;
	reg         next_b_ff;
	reg  [4:0]  scan_ptr_ff;

	wire [31:0] scan_mask = {scan_hi_ff, scan_lo_ff};
	wire [15:0] byte_m    = {{8{S_AXI_WSTRB_I[1]}}, {8{S_AXI_WSTRB_I[0]}}};
	// Instance two reaches only the lower sixteen inputs
	localparam  IN_COUNT  = ((INSTANCE_TWO != 0) && (NUM_INPUTS > 16)) ?
		16 : NUM_INPUTS;
	wire [15:0] chs0_impl = (INSTANCE_TWO != 0) ? `AIMX_MASK_CHS0_LO :
		`AIMX_MASK_CHS0;
	wire [15:0] chs123_rd = WIDE_RESOLUTION_MODE_I ? `AIMX_RESET_VAL :
		chs123_ff;

	// Byte lanes merge into the old value; unimplemented bits stay zero
	function [15:0] merge;
		input [15:0] old;
		input [15:0] data;
		input [15:0] strb;
		input [15:0] impl;
		begin
			merge = ((old & ~strb) | (data & strb)) & impl;
		end
	endfunction

	// ======================================================================
	// Bus slave: write address and data taken together, one at a time
	wire        wr_go = S_AXI_AWVALID_I & S_AXI_WVALID_I & ~S_AXI_BVALID_O;
	// Offsets decode on the low address byte; upper bits alias
	wire [7:0]  wa    = {S_AXI_AWADDR_I[7:2], 2'h0};
	wire [7:0]  ra    = {S_AXI_ARADDR_I[7:2], 2'h0};
	wire        rd_go = S_AXI_ARVALID_I & ~S_AXI_RVALID_O;
	reg         wr_hit;
	reg         rd_hit;
	reg  [15:0] rd_val;

	assign S_AXI_AWREADY_O = wr_go;
	assign S_AXI_WREADY_O  = wr_go;
	assign S_AXI_ARREADY_O = rd_go;

	always @* begin
		case (wa)
		`AIMX_OFF_DEPTH, `AIMX_OFF_CHS123, `AIMX_OFF_CHS0, `AIMX_OFF_SCAN_HI,
		`AIMX_OFF_SCAN_LO, `AIMX_OFF_STATUS: wr_hit = 1'b1;
		`AIMX_OFF_PIN_DIGITAL_SELECT_HI: wr_hit = (INSTANCE_TWO == 0);
		default: wr_hit = 1'b0;
		endcase
	end

	always @* begin
		rd_hit = 1'b1;
		case (ra)
		`AIMX_OFF_DEPTH:   rd_val = depth_ff;
		`AIMX_OFF_CHS123:  rd_val = chs123_rd;
		`AIMX_OFF_CHS0:    rd_val = chs0_ff;
		`AIMX_OFF_SCAN_HI: rd_val = scan_hi_ff;
		`AIMX_OFF_SCAN_LO: rd_val = scan_lo_ff;
		`AIMX_OFF_PIN_DIGITAL_SELECT_HI: begin
			rd_val = pin_digital_select_hi_ff;
			rd_hit = (INSTANCE_TWO == 0);
		end
		// Status shows the live sequencer state
		`AIMX_OFF_STATUS: begin
			rd_val = `AIMX_RESET_VAL;
			rd_val[`AIMX_ST_BUSY_BIT]  = busy_ff;
			rd_val[`AIMX_ST_SMPB_BIT]  = ACTIVE_SAMPLE_B_O;
			rd_val[`AIMX_ST_NEXTB_BIT] = next_b_ff;
			rd_val[`AIMX_ST_PTR_LSB +: 5] = scan_ptr_ff;
		end
		default: begin
			rd_val = `AIMX_RESET_VAL;
			rd_hit = 1'b0;
		end
		endcase
	end

	always @(posedge CORE_CLK_I) begin
		if (!RESET_N_I) begin
			depth_ff       <= `AIMX_RESET_VAL;
			chs123_ff      <= `AIMX_RESET_VAL;
			chs0_ff        <= `AIMX_RESET_VAL;
			scan_hi_ff     <= `AIMX_RESET_VAL;
			scan_lo_ff     <= `AIMX_RESET_VAL;
			pin_digital_select_hi_ff     <= `AIMX_RESET_VAL;
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O  <= `AIMX_RESP_OKAY;
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RRESP_O  <= `AIMX_RESP_OKAY;
			S_AXI_RDATA_O  <= 32'h00000000;
		end else begin
			if (wr_go) begin
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O  <= wr_hit ? `AIMX_RESP_OKAY : `AIMX_RESP_DECERR;
				case (wa)
				`AIMX_OFF_DEPTH: depth_ff <= merge(depth_ff,
					S_AXI_WDATA_I[15:0], byte_m, `AIMX_MASK_DEPTH);
				`AIMX_OFF_CHS123: if (!WIDE_RESOLUTION_MODE_I)
					chs123_ff <= merge(chs123_ff, S_AXI_WDATA_I[15:0], byte_m,
						`AIMX_MASK_CHS123);
				`AIMX_OFF_CHS0: chs0_ff <= merge(chs0_ff,
					S_AXI_WDATA_I[15:0], byte_m, chs0_impl);
				`AIMX_OFF_SCAN_HI: scan_hi_ff <= merge(scan_hi_ff,
					S_AXI_WDATA_I[15:0], byte_m, `AIMX_MASK_FULL);
				`AIMX_OFF_SCAN_LO: scan_lo_ff <= merge(scan_lo_ff,
					S_AXI_WDATA_I[15:0], byte_m, `AIMX_MASK_FULL);
				`AIMX_OFF_PIN_DIGITAL_SELECT_HI: if (INSTANCE_TWO == 0)
					pin_digital_select_hi_ff <= merge(pin_digital_select_hi_ff, S_AXI_WDATA_I[15:0],
						byte_m, `AIMX_MASK_FULL);
				// Status and unmapped writes are answered but change nothing
				default: ;
				endcase
			end else if (S_AXI_BREADY_I) begin
				S_AXI_BVALID_O <= 1'b0;
			end
			if (rd_go) begin
				S_AXI_RVALID_O <= 1'b1;
				S_AXI_RRESP_O  <= rd_hit ? `AIMX_RESP_OKAY : `AIMX_RESP_DECERR;
				S_AXI_RDATA_O  <= {16'h0000, rd_val};
			end else if (S_AXI_RREADY_I) begin
				S_AXI_RVALID_O <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Scan pointer: next enabled input after the current one
	reg  [4:0]  scan_next;
	reg         scan_found;
	reg  [4:0]  idx;
	integer     i;

	always @* begin
		scan_next  = scan_ptr_ff;
		scan_found = 1'b0;
		idx        = 5'h00;
		// Thirty-two probes wrap back to the current input last
		for (i = 1; i <= 32; i = i + 1) begin
			idx = scan_ptr_ff + i[4:0];
			if (!scan_found && scan_mask[idx]) begin
				scan_found = 1'b1;
				scan_next  = idx;
			end
		end
	end

	// ======================================================================
	// Effective pin modes
	wire [31:0] pin_dig;
	genvar      g;

	generate
		for (g = 0; g < 32; g = g + 1) begin : g_pin
			if (g < 16) begin : g_lo
				// Low pins follow the outside register; missing pins digital
				assign pin_dig[g] = CONVERTER_MODULE_DISABLE_I |
					(g >= IN_COUNT) | PIN_DIGITAL_LOW_I[g];
			end else begin : g_hi
				// Missing pins and the register-less instance stay digital
				assign pin_dig[g] = CONVERTER_MODULE_DISABLE_I |
					(g >= NUM_INPUTS) | (INSTANCE_TWO != 0) |
					pin_digital_select_hi_ff[g-16];
			end
		end
	endgenerate

	// ======================================================================
	// Sample sequencing and select latching
	wire        use_b   = ALTERNATE_SAMPLE_ENABLE_I & next_b_ff;
	wire        do_scan = SCAN_ENABLE_I & ~use_b;
	// A start while busy is dropped; the sequencer waits for done first
	wire        take    = SAMPLE_START_I & ~busy_ff;
	wire [4:0]  pos_fix = use_b ? chs0_ff[`AIMX_S0_SB_LSB +: 5] :
		chs0_ff[`AIMX_S0_SA_LSB +: 5];
	wire [4:0]  pos0    = do_scan ? scan_next : pos_fix;
	wire        pos_gone = ({27'h0, pos0} >= IN_COUNT);
	wire [1:0]  n123    = use_b ? chs123_rd[`AIMX_S123_NB_LSB +: 2] :
		chs123_rd[`AIMX_S123_NA_LSB +: 2];
	wire        s123    = use_b ? chs123_rd[`AIMX_S123_SB_BIT] :
		chs123_rd[`AIMX_S123_SA_BIT];

	always @(posedge CORE_CLK_I) begin
		if (!RESET_N_I) begin
			busy_ff           <= 1'b0;
			next_b_ff         <= 1'b0;
			scan_ptr_ff       <= 5'h1F;
			ACTIVE_SAMPLE_B_O <= 1'b0;
			SAMPLE_HOLD_O     <= 1'b0;
			CH0_POS_O         <= 5'h00;
			CH0_POS_REF_O     <= 1'b0;
			CH0_POS_AGND_O    <= 1'b0;
			CH0_NEG_AN1_O     <= 1'b0;
			BUFFER_WORDS_O    <= 8'h01;
			PIN_DIGITAL_HIGH_O <= 16'h0000;
		end else begin
			BUFFER_WORDS_O     <= 8'h01 << depth_ff[2:0];
			PIN_DIGITAL_HIGH_O <= pin_dig[31:16];
			if (!ALTERNATE_SAMPLE_ENABLE_I)
				next_b_ff <= 1'b0;
			// Restart from the lowest enabled input when scanning stops
			if (!SCAN_ENABLE_I)
				scan_ptr_ff <= 5'h1F;
			if (take) begin
				busy_ff           <= 1'b1;
				SAMPLE_HOLD_O     <= 1'b1;
				ACTIVE_SAMPLE_B_O <= use_b;
				CH0_POS_O         <= pos0;
				// Empty mask or missing input converts the reference
				CH0_POS_REF_O     <= (do_scan & ~scan_found) |
					pos_gone;
				CH0_POS_AGND_O    <= pin_dig[pos0];
				CH0_NEG_AN1_O     <= use_b ? chs0_ff[`AIMX_S0_NB_BIT] :
					chs0_ff[`AIMX_S0_NA_BIT];
				if (do_scan && SCAN_ENABLE_I)
					scan_ptr_ff <= scan_next;
			end else if (busy_ff && CONVERSION_DONE_I) begin
				busy_ff       <= 1'b0;
				SAMPLE_HOLD_O <= 1'b0;
				if (ALTERNATE_SAMPLE_ENABLE_I)
					next_b_ff <= ~next_b_ff;
			end
		end
	end

	// ======================================================================
	// Channel 1-3 selects, inputs 0-2 and negatives on the reference in 12-bit mode
	wire [14:0] nxt_ch123_pos;
	wire [14:0] nxt_ch123_neg;
	wire [2:0]  nxt_ch123_ref;

	// Channel n+1 sits at offset n inside each group of three inputs
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_ch
			localparam [4:0] CH = g;
			assign nxt_ch123_pos[g*5 +: 5] = s123 ? (5'h03 + CH) :
				CH;
			assign nxt_ch123_neg[g*5 +: 5] = n123[0] ? (5'h09 + CH) :
				(5'h06 + CH);
			assign nxt_ch123_ref[g] = ~n123[1] |
				WIDE_RESOLUTION_MODE_I;
		end
	endgenerate

	// One process owns all three channel fields
	always @(posedge CORE_CLK_I) begin
		if (!RESET_N_I) begin
			CH123_POS_O     <= 15'h0000;
			// Negatives start on the reference
			CH123_NEG_O     <= 15'h0000;
			CH123_NEG_REF_O <= 3'h7;
		end else if (take) begin
			CH123_POS_O     <= nxt_ch123_pos;
			CH123_NEG_O     <= nxt_ch123_neg;
			CH123_NEG_REF_O <= nxt_ch123_ref;
		end
	end

endmodule

// [hw/aimx_defines.vh]
// Register map, field layout and reset values of the input mux block
`ifndef AIMX_DEFINES_VH
`define AIMX_DEFINES_VH

// ==========================================================================
// Register byte offsets
`define AIMX_OFF_DEPTH     8'h00
`define AIMX_OFF_CHS123    8'h04
`define AIMX_OFF_CHS0      8'h08
`define AIMX_OFF_SCAN_HI   8'h0C
`define AIMX_OFF_SCAN_LO   8'h10
`define AIMX_OFF_PIN_DIGITAL_SELECT_HI   8'h14
`define AIMX_OFF_STATUS    8'h18

// ==========================================================================
// Implemented-bit masks and reset value
`define AIMX_MASK_DEPTH    16'h0007
`define AIMX_MASK_CHS123   16'h0707
`define AIMX_MASK_CHS0     16'h9F9F
`define AIMX_MASK_CHS0_LO  16'h8F8F
`define AIMX_MASK_FULL     16'hFFFF
`define AIMX_RESET_VAL     16'h0000

// ==========================================================================
// Field positions
`define AIMX_S123_NB_LSB   9
`define AIMX_S123_SB_BIT   8
`define AIMX_S123_NA_LSB   1
`define AIMX_S123_SA_BIT   0
`define AIMX_S0_NB_BIT     15
`define AIMX_S0_SB_LSB     8
`define AIMX_S0_NA_BIT     7
`define AIMX_S0_SA_LSB     0
`define AIMX_ST_BUSY_BIT   0
`define AIMX_ST_SMPB_BIT   1
`define AIMX_ST_NEXTB_BIT  2
`define AIMX_ST_PTR_LSB    4

// ==========================================================================
// Bus responses
`define AIMX_RESP_OKAY     2'h0
`define AIMX_RESP_DECERR   2'h3

`endif

// [testbench/aimx_top_checker.sv]
// Concurrent checks on the ports of the input mux register block
`timescale 1ns/1ps

module aimx_checker #(
	parameter ADDR_W = 8
) (
	input wire              CORE_CLK_I,
	input wire              RESET_N_I,
	input wire [ADDR_W-1:0] S_AXI_AWADDR_I,
	input wire              S_AXI_AWVALID_I,
	input wire              S_AXI_AWREADY_O,
	input wire [31:0]       S_AXI_WDATA_I,
	input wire [3:0]        S_AXI_WSTRB_I,
	input wire              ALTERNATE_SAMPLE_ENABLE_I,
	input wire              CONVERTER_MODULE_DISABLE_I,
	input wire              SAMPLE_START_I,
	input wire              CONVERSION_DONE_I,
	input wire [7:0]        BUFFER_WORDS_O,
	input wire              ACTIVE_SAMPLE_B_O,
	input wire              SAMPLE_HOLD_O,
	input wire [4:0]        CH0_POS_O,
	input wire [14:0]       CH123_POS_O,
	input wire [2:0]        CH123_NEG_REF_O,
	input wire [15:0]       PIN_DIGITAL_HIGH_O
);
	// Low three data bits of the last accepted write, whatever its offset
	reg [2:0] wd_ff;
	always @(posedge CORE_CLK_I)
		if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
			wd_ff <= S_AXI_WDATA_I[2:0];

	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESET_N_I);

	// ====================
	// Register side
	a_depth_words: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O &&
		S_AXI_AWADDR_I == 8'h00 && S_AXI_WSTRB_I[0]
		|=> ##1 BUFFER_WORDS_O == (8'h01 << wd_ff))
		else $error("depth words wrong");
	a_disable_digital: assert property (CONVERTER_MODULE_DISABLE_I
		|=> PIN_DIGITAL_HIGH_O == 16'hFFFF) else $error("pins not digital");

	// ====================
	// Sequencer side
	a_hold_start: assert property (SAMPLE_START_I && !SAMPLE_HOLD_O
		|=> SAMPLE_HOLD_O) else $error("hold did not rise");
	a_hold_stable: assert property (SAMPLE_HOLD_O && !CONVERSION_DONE_I
		|=> SAMPLE_HOLD_O && $stable(CH0_POS_O)) else $error("select moved");
	a_done_release: assert property (SAMPLE_HOLD_O && CONVERSION_DONE_I
		|=> !SAMPLE_HOLD_O) else $error("hold did not fall");
	a_sample_a: assert property (SAMPLE_START_I && !SAMPLE_HOLD_O &&
		!ALTERNATE_SAMPLE_ENABLE_I |=> !ACTIVE_SAMPLE_B_O)
		else $error("sample B without alternate");
	a_neg_ref_all: assert property (CH123_NEG_REF_O == 3'h0 ||
		CH123_NEG_REF_O == 3'h7) else $error("channels split on reference");
	a_pos_group: assert property (SAMPLE_HOLD_O |->
		CH123_POS_O == 15'h0820 || CH123_POS_O == 15'h1483)
		else $error("channel 1-3 positive group wrong");

	c_alt_b: cover property (SAMPLE_HOLD_O && ACTIVE_SAMPLE_B_O);
	c_disable: cover property (CONVERTER_MODULE_DISABLE_I);
	c_deep: cover property (BUFFER_WORDS_O == 8'h80);
endmodule

bind aimx_top aimx_checker #(.ADDR_W(ADDR_W)) i_aimx_checker (.*);

// [testbench/aimx_top_tb.sv]
// Self-checking bench for the input mux register block
`timescale 1ns/1ps
`include "aimx_defines.vh"

module aimx_top_tb;
	localparam int LIMIT = 5000;
	logic        CORE_CLK_I, RESET_N_I, S_AXI_AWVALID_I, S_AXI_AWREADY_O;
	logic        S_AXI_WVALID_I, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_BREADY_I;
	logic        S_AXI_ARVALID_I, S_AXI_ARREADY_O, S_AXI_RVALID_O, S_AXI_RREADY_I;
	logic        WIDE_RESOLUTION_MODE_I, ALTERNATE_SAMPLE_ENABLE_I;
	logic        SCAN_ENABLE_I, CONVERTER_MODULE_DISABLE_I, SAMPLE_START_I;
	logic        CONVERSION_DONE_I, ACTIVE_SAMPLE_B_O, SAMPLE_HOLD_O;
	logic        CH0_POS_REF_O, CH0_POS_AGND_O, CH0_NEG_AN1_O;
	logic [1:0]  S_AXI_BRESP_O, S_AXI_RRESP_O;
	logic [2:0]  CH123_NEG_REF_O;
	logic [3:0]  S_AXI_WSTRB_I;
	logic [4:0]  CH0_POS_O;
	logic [7:0]  S_AXI_AWADDR_I, S_AXI_ARADDR_I, BUFFER_WORDS_O;
	logic [14:0] CH123_POS_O, CH123_NEG_O;
	logic [15:0] PIN_DIGITAL_LOW_I, PIN_DIGITAL_HIGH_O;
	logic [31:0] S_AXI_WDATA_I, S_AXI_RDATA_O;
	int          num_errors = 0;
	int          checks = 0;
	int          cyc = 0;

	aimx_top i_aimx_top (.*);

	initial begin
		CORE_CLK_I = 1'h0;
		forever #12.5 CORE_CLK_I = ~CORE_CLK_I;
	end

	// ====================
	// Shared tasks
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Both channels offered together; the slave takes them in one edge
	task automatic wr(input logic [7:0] a, input logic [15:0] d,
		input logic [1:0] r = `AIMX_RESP_OKAY);
		S_AXI_AWADDR_I <= a;
		S_AXI_WDATA_I <= {16'h0000, d};
		S_AXI_AWVALID_I <= 1'h1;
		S_AXI_WVALID_I <= 1'h1;
		S_AXI_BREADY_I <= 1'h1;
		// Settled handshakes are seen at the falling edge before the take
		do @(negedge CORE_CLK_I);
		while (!(S_AXI_AWREADY_O && S_AXI_WREADY_O));
		@(posedge CORE_CLK_I);
		S_AXI_AWVALID_I <= 1'h0;
		S_AXI_WVALID_I <= 1'h0;
		do @(negedge CORE_CLK_I); while (!S_AXI_BVALID_O);
		chk("bresp", {30'h0, r}, {30'h0, S_AXI_BRESP_O});
		@(posedge CORE_CLK_I);
		S_AXI_BREADY_I <= 1'h0;
		@(posedge CORE_CLK_I);
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] d,
		input logic [1:0] r = `AIMX_RESP_OKAY);
		S_AXI_ARADDR_I <= a;
		S_AXI_ARVALID_I <= 1'h1;
		S_AXI_RREADY_I <= 1'h1;
		do @(negedge CORE_CLK_I); while (!S_AXI_ARREADY_O);
		@(posedge CORE_CLK_I);
		S_AXI_ARVALID_I <= 1'h0;
		do @(negedge CORE_CLK_I); while (!S_AXI_RVALID_O);
		chk("rdata", {16'h0000, d}, S_AXI_RDATA_O);
		chk("rresp", {30'h0, r}, {30'h0, S_AXI_RRESP_O});
		@(posedge CORE_CLK_I);
		S_AXI_RREADY_I <= 1'h0;
		@(posedge CORE_CLK_I);
	endtask

	task automatic conv();
		SAMPLE_START_I <= 1'h1;
		@(posedge CORE_CLK_I);
		SAMPLE_START_I <= 1'h0;
		@(posedge CORE_CLK_I);
		chk("hold", 32'h1, {31'h0, SAMPLE_HOLD_O});
		CONVERSION_DONE_I <= 1'h1;
		@(posedge CORE_CLK_I);
		CONVERSION_DONE_I <= 1'h0;
		@(posedge CORE_CLK_I);
		chk("hold", 32'h0, {31'h0, SAMPLE_HOLD_O});
	endtask

	task automatic sel_chk(input logic [2:0] c, input logic b);
		chk("sample_b", {31'h0, b}, {31'h0, ACTIVE_SAMPLE_B_O});
		chk("pos123", c[0] ? 32'h1483 : 32'h0820, {17'h0, CH123_POS_O});
		chk("negref", c[2] ? 32'h0 : 32'h7, {29'h0, CH123_NEG_REF_O});
		if (c[2])
			chk("neg123", c[1] ? 32'h2D49 : 32'h20E6, {17'h0, CH123_NEG_O});
	endtask

	// ====================
	// Scenarios
	task automatic t_depth();
		for (int i = 0; i < 6; i++)
			rd(8'(i * 4), 16'h0000);
		for (int c = 0; c < 8; c++) begin
			wr(`AIMX_OFF_DEPTH, 16'hFFF8 | 16'(c));
			rd(`AIMX_OFF_DEPTH, 16'(c));
			chk("words", 32'h1 << c, {24'h0, BUFFER_WORDS_O});
		end
		// Unmapped place must leave the depth untouched
		wr(8'h1C, 16'hFFFF, `AIMX_RESP_DECERR);
		rd(8'h1C, 16'h0000, `AIMX_RESP_DECERR);
		rd(`AIMX_OFF_DEPTH, 16'h0007);
		$display("t_depth done");
	endtask

	task automatic t_sec();
		logic [2:0] k;
		ALTERNATE_SAMPLE_ENABLE_I <= 1'h1;
		for (int i = 0; i < 8; i++) begin
			k = 3'(i);
			wr(`AIMX_OFF_CHS123, {5'h1F, ~k, 5'h1F, k});
			rd(`AIMX_OFF_CHS123, {5'h00, ~k, 5'h00, k});
			conv();
			sel_chk(k, 1'h0);
			conv();
			sel_chk(~k, 1'h1);
		end
		WIDE_RESOLUTION_MODE_I <= 1'h1;
		@(posedge CORE_CLK_I);
		rd(`AIMX_OFF_CHS123, 16'h0000);
		wr(`AIMX_OFF_CHS123, 16'h0101);
		WIDE_RESOLUTION_MODE_I <= 1'h0;
		@(posedge CORE_CLK_I);
		rd(`AIMX_OFF_CHS123, 16'h0007);
		$display("t_sec done");
	endtask

	task automatic t_pri();
		wr(`AIMX_OFF_CHS0, 16'hFE71);
		rd(`AIMX_OFF_CHS0, 16'h9E11);
		conv();
		chk("ch0pos", 32'h11, {27'h0, CH0_POS_O});
		chk("ch0neg", 32'h0, {31'h0, CH0_NEG_AN1_O});
		conv();
		chk("ch0pos", 32'h1E, {27'h0, CH0_POS_O});
		chk("ch0neg", 32'h1, {31'h0, CH0_NEG_AN1_O});
		$display("t_pri done");
	endtask

	task automatic t_scan();
		logic [4:0] seq [4] = '{5'h02, 5'h05, 5'h1F, 5'h02};
		ALTERNATE_SAMPLE_ENABLE_I <= 1'h0;
		wr(`AIMX_OFF_SCAN_LO, 16'h0024);
		wr(`AIMX_OFF_SCAN_HI, 16'h8000);
		rd(`AIMX_OFF_SCAN_HI, 16'h8000);
		SCAN_ENABLE_I <= 1'h1;
		foreach (seq[i]) begin
			conv();
			chk("scan", {27'h0, seq[i]}, {27'h0, CH0_POS_O});
			chk("ref", 32'h0, {31'h0, CH0_POS_REF_O});
		end
		rd(`AIMX_OFF_STATUS, 16'h0020);
		// Empty mask converts the reference
		wr(`AIMX_OFF_SCAN_LO, 16'h0000);
		wr(`AIMX_OFF_SCAN_HI, 16'h0000);
		conv();
		chk("ref", 32'h1, {31'h0, CH0_POS_REF_O});
		SCAN_ENABLE_I <= 1'h0;
		$display("t_scan done");
	endtask

	task automatic t_pin();
		wr(`AIMX_OFF_PIN_DIGITAL_SELECT_HI, 16'hA5C3);
		rd(`AIMX_OFF_PIN_DIGITAL_SELECT_HI, 16'hA5C3);
		chk("pinhi", 32'hA5C3, {16'h0, PIN_DIGITAL_HIGH_O});
		wr(`AIMX_OFF_CHS0, 16'h0011);
		conv();
		chk("agnd", 32'h1, {31'h0, CH0_POS_AGND_O});
		PIN_DIGITAL_LOW_I <= 16'h0004;
		wr(`AIMX_OFF_CHS0, 16'h0002);
		conv();
		chk("agnd", 32'h1, {31'h0, CH0_POS_AGND_O});
		wr(`AIMX_OFF_CHS0, 16'h0012);
		conv();
		chk("agnd", 32'h0, {31'h0, CH0_POS_AGND_O});
		CONVERTER_MODULE_DISABLE_I <= 1'h1;
		repeat (2) @(posedge CORE_CLK_I);
		chk("pinhi", 32'hFFFF, {16'h0, PIN_DIGITAL_HIGH_O});
		CONVERTER_MODULE_DISABLE_I <= 1'h0;
		repeat (2) @(posedge CORE_CLK_I);
		chk("pinhi", 32'hA5C3, {16'h0, PIN_DIGITAL_HIGH_O});
		$display("t_pin done");
	endtask

	// ====================
	// Main sequence and hang guard
	initial begin
		{S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I} = 3'h0;
		{S_AXI_ARVALID_I, S_AXI_RREADY_I, SAMPLE_START_I} = 3'h0;
		{WIDE_RESOLUTION_MODE_I, ALTERNATE_SAMPLE_ENABLE_I} = 2'h0;
		{SCAN_ENABLE_I, CONVERTER_MODULE_DISABLE_I} = 2'h0;
		CONVERSION_DONE_I = 1'h0;
		S_AXI_AWADDR_I = 8'h00;
		S_AXI_ARADDR_I = 8'h00;
		S_AXI_WDATA_I = 32'h0;
		S_AXI_WSTRB_I = 4'h3;
		PIN_DIGITAL_LOW_I = 16'h0000;
		RESET_N_I = 1'h0;
		repeat (6) @(posedge CORE_CLK_I);
		RESET_N_I <= 1'h1;
		@(posedge CORE_CLK_I);
		chk("words", 32'h1, {24'h0, BUFFER_WORDS_O});
		t_depth();
		t_sec();
		t_pri();
		t_scan();
		t_pin();
		finish_test();
	end

	always @(posedge CORE_CLK_I) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			num_errors++;
			finish_test();
		end
	end
endmodule
